/* File: ald_datapath.sv */
`timescale 1ns/1ps
`include "ald_defines.svh"
// Contract
// - Register-register words carry opcode in bits 0-5, dest in 6-10, A in 11-15, B in 16-20, zeros in 21-31.
// - Register-immediate words carry opcode, dest and one source, then a 16-bit immediate in bits 16-31.
// - The register add family writes src A plus src B into the destination.
// - Keep bit 3 set leaves the carry flag alone; cleared, the carry flag takes the add carry out.
// - Carry-use bit 4 set adds the carry flag as carry-in; cleared, the add has no carry-in.
// - Keep forms set bit 3, carry-using forms set bit 4, the combined form sets both.
// - The immediate add family adds the sign-extended immediate to src A with the same bit meanings.
// - The immediate is the sign-extended field, or the 32-bit prefixed value when a prefix precedes.
// - Register AND writes src A AND src B into the destination and leaves the carry flag alone.
// - With the zero-word trap and exceptions enabled, the all-zero word raises an illegal trap.
module ald_datapath #(
   parameter logic       ZERO_WORD_TRAP_PARAM = 1'b0,       // Trap reset value
   parameter logic       EXC_EN_RESET         = 1'b1,       // Exceptions enabled at reset
   parameter logic [5:0] AND_OPCODE           = 6'b100001   // Register AND opcode
) (
   input  wire logic               clock,       // 25 MHz core clock
   input  wire logic               resetn,      // Async reset, active low
   input  wire logic               psel,        // APB select
   input  wire logic               penable,     // APB access phase
   input  wire logic               pwrite,      // APB write
   input  wire logic [11:0]        paddr,       // APB byte address
   input  wire logic [31:0]        pwdata,      // APB write data
   output logic                    pready,      // APB ready
   output logic [31:0]             prdata,      // APB read data
   output logic                    pslverr,     // APB error
   input  wire ald_pkg::ald_instr_s instr,      // Instruction from decode
   input  wire logic [31:0]        src_reg_a,   // Register file port A
   input  wire logic [31:0]        src_reg_b,   // Register file port B
   output ald_pkg::ald_wb_s        wb,          // Result write-back
   output logic                    illegal_trap,// Illegal instruction pulse
   output logic                    status_carry_flag, // Carry in status word
   output logic                    irq          // Level interrupt
);
   import ald_pkg::*;

   // Parameter sanity: the AND opcode must not fall into the add family
   if (AND_OPCODE[5:4] == 2'b00 && AND_OPCODE[0] == 1'b0) begin : g_chk
      $error("AND_OPCODE collides with the add family");
   end

   // Registers
   logic                     trap_en_r;
   logic                     exc_en_r;
   logic                     carry_r;
   logic [`ALD_IRQ_W-1:0]    irq_sts_r;
   logic [`ALD_IRQ_W-1:0]    irq_mask_r;
   logic [31:0]              op_count_r;
   ald_wb_s                  wb_r;
   logic                     trap_r;
   logic                     irq_r;
   logic                     pready_r;
   logic [31:0]              prdata_r;
   logic                     pslverr_r;

   // Decode wires
   logic [5:0]               opc;
   logic [4:0]               dest;
   logic                     type_b;
   logic                     keep_bit;
   logic                     cuse_bit;
   logic                     add_family;
   logic                     tail_zero;
   logic [31:0]              imm_ext;
   logic [31:0]              opnd_b;
   logic                     cin;
   logic [32:0]              sum;
   logic [31:0]              and_res;
   ald_op_e                  op_kind;
   logic                     carry_upd;
   logic                     unknown_op;

   // APB strobes
   logic                     apb_setup;
   logic                     apb_wr;
   logic                     sel_ctrl;
   logic                     sel_msw;
   logic                     sel_sts;
   logic                     sel_mask;
   logic                     sel_cnt;
   logic                     sel_hit;
   logic [`ALD_IRQ_W-1:0]    irq_set;
   logic [`ALD_IRQ_W-1:0]    irq_clr;
   logic [`ALD_IRQ_W-1:0]    irq_sts_nxt;

   // Field extraction, manual bit 0 is the word's top bit
   assign opc      = instr.word[`ALD_OPC_HI:`ALD_OPC_LO];
   assign dest     = instr.word[`ALD_RD_HI:`ALD_RD_LO];
   assign type_b   = instr.word[`ALD_BIT_TYPEB];
   assign keep_bit = instr.word[`ALD_BIT_KEEP];
   assign cuse_bit = instr.word[`ALD_BIT_CUSE];
   assign tail_zero = (instr.word[`ALD_ZERO_HI:`ALD_ZERO_LO] == 11'h000);

   // Add family: opcode 0,0,T,K,C,0 where T picks the immediate form
   assign add_family = (opc[5:4] == 2'b00) && !instr.word[`ALD_BIT_ADD_LOW];

   // Immediate operand, prefix overrides plain sign extension
   always_comb begin
      if (instr.pfx_valid) begin
         imm_ext = {instr.pfx_hi, instr.word[`ALD_IMM_HI:`ALD_IMM_LO]};
      end else begin
         imm_ext = {{16{instr.word[`ALD_IMM_HI]}},
                    instr.word[`ALD_IMM_HI:`ALD_IMM_LO]};
      end
   end

   // Second operand: register B for type A, immediate for type B
   assign opnd_b = type_b ? imm_ext : src_reg_b;

   // Carry-in comes from the flag only when the opcode asks for it;
   // the decision itself never looks at the flag
   assign cin = cuse_bit & carry_r;

   // One 33-bit adder serves all four add variants
   assign sum     = {1'b0, src_reg_a} + {1'b0, opnd_b} + {32'h00000000, cin};
   assign and_res = src_reg_a & src_reg_b;

   // Operation class; the zero word is checked first so it does not add while trap and exceptions are enabled
   always_comb begin
      op_kind = ALD_OP_NONE;
      if (!instr.valid) begin
         op_kind = ALD_OP_NONE;
      end else if (instr.word == 32'h00000000 && trap_en_r && exc_en_r) begin
         op_kind = ALD_OP_TRAP;
      end else if (add_family && (type_b || tail_zero)) begin
         op_kind = ALD_OP_ADD;
      end else if (opc == AND_OPCODE && tail_zero) begin
         op_kind = ALD_OP_AND;
      end else begin
         op_kind = ALD_OP_NONE;
      end
   end

   // Words this slice does not serve are flagged, not executed
   assign unknown_op = instr.valid && (op_kind == ALD_OP_NONE);

   // Carry updates only for adds with the keep bit clear
   assign carry_upd = (op_kind == ALD_OP_ADD) && !keep_bit;

   // Write-back register, result visible one edge after the instruction
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         wb_r <= '0;
      end else begin
         wb_r.valid <= (op_kind == ALD_OP_ADD) || (op_kind == ALD_OP_AND);
         wb_r.dest  <= dest;
         if (op_kind == ALD_OP_AND) begin
            wb_r.data <= and_res;
         end else begin
            wb_r.data <= sum[31:0];
         end
      end
   end

   // Trap pulse toward the exception logic
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         trap_r <= 1'b0;
      end else begin
         trap_r <= (op_kind == ALD_OP_TRAP);
      end
   end

   // APB decode, single-cycle answer in the access phase
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pready_r && pwrite;
   assign sel_ctrl  = (paddr == `ALD_OFS_CTRL);
   assign sel_msw   = (paddr == `ALD_OFS_MSW);
   assign sel_sts   = (paddr == `ALD_OFS_IRQ_STATUS);
   assign sel_mask  = (paddr == `ALD_OFS_IRQ_MASK);
   assign sel_cnt   = (paddr == `ALD_OFS_OP_COUNT);
   assign sel_hit   = sel_ctrl || sel_msw || sel_sts || sel_mask || sel_cnt;

   // Carry flag: an executing add with the keep bit clear wins over a software write
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         carry_r <= `ALD_RST_CARRY;
      end else if (carry_upd) begin
         carry_r <= sum[32];
      end else if (apb_wr && sel_msw) begin
         carry_r <= pwdata[`ALD_MSW_CARRY];
      end
   end

   // Control bits; trap enable resets to the configuration parameter
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         trap_en_r <= ZERO_WORD_TRAP_PARAM;
         exc_en_r  <= EXC_EN_RESET;
      end else if (apb_wr && sel_ctrl) begin
         trap_en_r <= pwdata[`ALD_CTRL_TRAP_EN];
         exc_en_r  <= pwdata[`ALD_CTRL_EXC_EN];
      end
   end

   // Interrupt mask
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_mask_r <= `ALD_RST_MASK;
      end else if (apb_wr && sel_mask) begin
         irq_mask_r <= pwdata[`ALD_IRQ_W-1:0];
      end
   end

   // Sticky events; a set in the clearing cycle survives
   always_comb begin
      irq_set = '0;
      irq_set[`ALD_IRQ_TRAP]    = (op_kind == ALD_OP_TRAP);
      irq_set[`ALD_IRQ_UNKNOWN] = unknown_op;
      irq_set[`ALD_IRQ_CARRY]   = carry_upd && sum[32];
      irq_clr     = (apb_wr && sel_sts) ? pwdata[`ALD_IRQ_W-1:0] : '0;
      irq_sts_nxt = (irq_sts_r & ~irq_clr) | irq_set;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_sts_r <= '0;
      end else begin
         irq_sts_r <= irq_sts_nxt;
      end
   end

   // Interrupt line follows the next status so it is a plain flop
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_sts_nxt & irq_mask_r);
      end
   end

   // Count of executed adds and ANDs, wraps silently
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         op_count_r <= 32'h00000000;
      end else if (op_kind == ALD_OP_ADD || op_kind == ALD_OP_AND) begin
         op_count_r <= op_count_r + 32'h00000001;
      end
   end

   // Read data and error captured in setup, presented in access;
   // registering costs nothing since APB has the setup cycle anyway
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (apb_setup) begin
         pready_r  <= 1'b1;
         pslverr_r <= !sel_hit;
         prdata_r  <= 32'h00000000;
         if (!pwrite) begin
            if (sel_ctrl) begin
               prdata_r[`ALD_CTRL_TRAP_EN] <= trap_en_r;
               prdata_r[`ALD_CTRL_EXC_EN]  <= exc_en_r;
            end else if (sel_msw) begin
               prdata_r[`ALD_MSW_CARRY] <= carry_r;
            end else if (sel_sts) begin
               prdata_r[`ALD_IRQ_W-1:0] <= irq_sts_r;
            end else if (sel_mask) begin
               prdata_r[`ALD_IRQ_W-1:0] <= irq_mask_r;
            end else if (sel_cnt) begin
               prdata_r <= op_count_r;
            end
         end
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // Outputs straight from flops
   assign pready            = pready_r;
   assign prdata            = prdata_r;
   assign pslverr           = pslverr_r;
   assign wb                = wb_r;
   assign illegal_trap      = trap_r;
   assign status_carry_flag = carry_r;
   assign irq               = irq_r;

endmodule

/* File: ald_datapath_sva.sv */
`timescale 1ns/1ps
module ald_datapath_sva
   import ald_pkg::*;
#(
   parameter logic [5:0] AND_OPCODE = 6'b100001 // AND opcode
) (
   input wire logic        clock,            // Core clock
   input wire logic        resetn,           // Active-low reset
   input wire logic        psel,             // APB select
   input wire logic        penable,          // APB access
   input wire logic        pwrite,           // APB write
   input wire logic        pready,           // APB ready
   input wire ald_instr_s  instr,            // Issued instruction
   input wire logic [31:0] src_reg_a,        // Operand A
   input wire logic [31:0] src_reg_b,        // Operand B
   input wire ald_wb_s     wb,               // Write-back
   input wire logic        illegal_trap,     // Trap pulse
   input wire logic        status_carry_flag // Carry flag
);
   logic [31:0] w, opb;
   logic [32:0] sum;
   logic        is_add, is_and, bad_a, zero_in, sw_wr;

   // Independent decode of the add family and AND
   assign w       = instr.word;
   assign zero_in = instr.valid && w == 32'h0;
   assign is_add  = instr.valid && !zero_in && w[31:30] == 2'h0 && !w[26]
                    && (w[29] || w[10:0] == 11'h0);
   assign bad_a   = instr.valid && w[31:29] == 3'h0 && !w[26] && w[10:0] != 11'h0;
   assign is_and  = instr.valid && w[31:26] == AND_OPCODE && w[10:0] == 11'h0;
   assign opb     = !w[29] ? src_reg_b : instr.pfx_valid ? {instr.pfx_hi, w[15:0]}
                    : {{16{w[15]}}, w[15:0]};
   assign sum     = {1'b0, src_reg_a} + {1'b0, opb} + {32'h0, w[27] & status_carry_flag};
   // Software may also move the carry; such cycles are excluded
   assign sw_wr   = psel && penable && pwrite && pready;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   add_result_a: assert property (is_add |=> wb.valid
      && wb.data == $past(sum[31:0])) else $error("add result wrong");
   carry_load_a: assert property (is_add && !w[28]
      |=> status_carry_flag == $past(sum[32])) else $error("carry not loaded");
   carry_keep_a: assert property (is_add && w[28] && !sw_wr
      |=> $stable(status_carry_flag)) else $error("carry not kept");
   and_result_a: assert property (is_and |=> wb.valid
      && wb.data == ($past(src_reg_a) & $past(src_reg_b))) else $error("and result wrong");
   and_carry_a: assert property (is_and && !sw_wr
      |=> $stable(status_carry_flag)) else $error("and moved carry");
   bad_format_a: assert property (bad_a |=> !wb.valid) else $error("bad word written");
   idle_quiet_a: assert property (!instr.valid |=> !wb.valid && !illegal_trap)
      else $error("output without instruction");
   trap_cause_a: assert property (illegal_trap |-> !wb.valid && $past(zero_in))
      else $error("trap without zero word");

   cover property (is_add && w[27] && status_carry_flag);
   cover property (is_add && w[29] && instr.pfx_valid);
   cover property (illegal_trap);
endmodule

bind ald_datapath ald_datapath_sva #(.AND_OPCODE(AND_OPCODE)) u_sva (.clock, .resetn,
   .psel, .penable, .pwrite, .pready, .instr, .src_reg_a, .src_reg_b, .wb,
   .illegal_trap, .status_carry_flag);

/* File: ald_datapath_test.sv */
`timescale 1ns/1ps
`include "ald_defines.svh"
module ald_datapath_test;
   import ald_pkg::*;
   logic        clock, resetn, psel, penable, pwrite, pready, pslverr;
   logic        illegal_trap, status_carry_flag, irq, cv, ec;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, src_reg_a, src_reg_b, rd, w;
   ald_instr_s  instr;
   ald_wb_s     wb;
   int          err_count, n_compared;

   ald_datapath u_dut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pready, .prdata, .pslverr, .instr, .src_reg_a, .src_reg_b, .wb,
      .illegal_trap, .status_carry_flag, .irq);
   ald_rf_model u_rf (.clock, .resetn, .instr, .wb, .src_reg_a, .src_reg_b);

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   task automatic report_and_stop();
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      // Sample pready, data and error at the rising edge itself
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         report_and_stop();
      end else begin
         rd = prdata;
         ec = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   // Issue one word; the result stands one edge later
   task automatic issue(input logic [31:0] iw, input logic pv, input logic [15:0] ph);
      @(posedge clock);
      instr <= '{1'b1, iw, pv, ph};
      @(posedge clock);
      instr.valid <= 1'b0;
      #1;
   endtask

   initial begin
      resetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      instr = '0;
      err_count = 0;
      n_compared = 0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      // Reset values, then an unmapped place
      apb(1'b0, `ALD_OFS_CTRL, 32'h0);
      chk(rd, 32'h1 << `ALD_CTRL_EXC_EN);
      for (int a = 4; a <= 16; a += 4) begin
         apb(1'b0, 12'(a), 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk(ec, 32'h1);
      // Every keep/carry-use mix, register and immediate forms
      for (int i = 0; i < 8; i++) begin
         cv = i[0] ^ i[1];
         apb(1'b1, `ALD_OFS_MSW, {31'h0, cv});
         w = i[2] ? {3'b001, i[0], i[1], 1'b0, 5'd31, 5'd2, 16'hFFFF}
                  : {3'b000, i[0], i[1], 1'b0, 5'd31, 5'd1, 5'd2, 11'h0};
         issue(w, 1'b0, 16'h0);
         chk(wb.valid, 32'h1);
         chk(wb.dest, 32'd31);
         chk(wb.data, {31'h0, i[1] & cv});
         chk(status_carry_flag, i[0] ? cv : 1'b1);
      end
      // Carry out of one add feeds the very next word
      @(posedge clock);
      instr <= '{1'b1, {6'h00, 5'd31, 5'd1, 5'd2, 11'h0}, 1'b0, 16'h0};
      issue({6'h02, 5'd31, 5'd3, 5'd4, 11'h0}, 1'b0, 16'h0);
      chk(wb.data, 32'h77777778);
      issue({6'h08, 5'd31, 5'd2, 16'h8000}, 1'b1, 16'h1234);
      chk(wb.data, 32'h12348001);
      chk(status_carry_flag, 32'h0);
      apb(1'b1, `ALD_OFS_MSW, 32'h1);
      issue({6'b100001, 5'd31, 5'd3, 5'd5, 11'h0}, 1'b0, 16'h0);
      chk(wb.data, 32'h11111111);
      chk(status_carry_flag, 32'h1);
      // Carry-out events so far, nothing refused or trapped
      apb(1'b0, `ALD_OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h4);
      // Malformed register word is refused and raises its event
      apb(1'b1, `ALD_OFS_IRQ_STATUS, 32'h7);
      issue({6'h00, 5'd31, 5'd1, 5'd2, 11'h001}, 1'b0, 16'h0);
      chk(wb.valid, 32'h0);
      apb(1'b0, `ALD_OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h2);
      chk(irq, 32'h0);
      apb(1'b1, `ALD_OFS_IRQ_MASK, 32'h2);
      apb(1'b0, `ALD_OFS_IRQ_MASK, 32'h0);
      chk(irq, 32'h1);
      apb(1'b1, `ALD_OFS_IRQ_STATUS, 32'h2);
      apb(1'b0, `ALD_OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk(irq, 32'h0);
      // All-zero word: plain add, then trapped once enabled
      issue(32'h0, 1'b0, 16'h0);
      chk(wb.valid, 32'h1);
      apb(1'b1, `ALD_OFS_CTRL, 32'h3);
      issue(32'h0, 1'b0, 16'h0);
      chk(illegal_trap, 32'h1);
      chk(wb.valid, 32'h0);
      apb(1'b0, `ALD_OFS_IRQ_STATUS, 32'h0);
      chk(rd, 32'h1);
      // Thirteen words executed; the refused and trapped ones do not count
      apb(1'b0, `ALD_OFS_OP_COUNT, 32'h0);
      chk(rd, 32'hD);
      report_and_stop();
   end
endmodule

/* File: ald_defines.svh */
`ifndef ALD_DEFINES_SVH
`define ALD_DEFINES_SVH

// Register byte offsets on the APB side
`define ALD_OFS_CTRL        12'h000
`define ALD_OFS_MSW         12'h004
`define ALD_OFS_IRQ_STATUS  12'h008
`define ALD_OFS_IRQ_MASK    12'h00C
`define ALD_OFS_OP_COUNT    12'h010

// Control register fields
`define ALD_CTRL_TRAP_EN    0
`define ALD_CTRL_EXC_EN     1

// Machine status word fields
`define ALD_MSW_CARRY       0

// Interrupt status and mask fields
`define ALD_IRQ_TRAP        0
`define ALD_IRQ_UNKNOWN     1
`define ALD_IRQ_CARRY       2
`define ALD_IRQ_W           3

// Reset values
`define ALD_RST_MASK        3'h0
`define ALD_RST_CARRY       1'b0

// Instruction word fields, bit 0 of the manual is word bit 31
`define ALD_OPC_HI          31
`define ALD_OPC_LO          26
`define ALD_RD_HI           25
`define ALD_RD_LO           21
`define ALD_RA_HI           20
`define ALD_RA_LO           16
`define ALD_RB_HI           15
`define ALD_RB_LO           11
`define ALD_ZERO_HI         10
`define ALD_ZERO_LO         0
`define ALD_IMM_HI          15
`define ALD_IMM_LO          0
`define ALD_BIT_TYPEB       29
`define ALD_BIT_KEEP        28
`define ALD_BIT_CUSE        27
`define ALD_BIT_ADD_LOW     26

`endif

/* File: ald_pkg.sv */
package ald_pkg;

   // Instruction as handed over by the decode stage
   typedef struct packed {
      logic        valid;      // Instruction present this cycle
      logic [31:0] word;       // Raw instruction word
      logic        pfx_valid;  // Preceded by immediate prefix
      logic [15:0] pfx_hi;     // Upper half held by the prefix
   } ald_instr_s;

   // Write-back toward the register file
   typedef struct packed {
      logic        valid;      // Write destination this cycle
      logic [4:0]  dest;       // Destination register index
      logic [31:0] data;       // Result value
   } ald_wb_s;

   // Operation class after decode
   typedef enum logic [1:0] {
      ALD_OP_NONE,
      ALD_OP_ADD,
      ALD_OP_AND,
      ALD_OP_TRAP
   } ald_op_e;

endpackage

/* File: ald_rf_model.sv */
`timescale 1ns/1ps
// Register file stand-in that feeds the datapath operands
module ald_rf_model
   import ald_pkg::*;
(
   input  wire logic       clock,     // Core clock
   input  wire logic       resetn,    // Active-low reset
   input  wire ald_instr_s instr,     // Instruction in flight
   input  wire ald_wb_s    wb,        // Write-back from datapath
   output logic [31:0]     src_reg_a, // Port A data
   output logic [31:0]     src_reg_b  // Port B data
);
   logic [31:0] regs_r [32];

   // Seeded contents so every sum is predictable; r0 never written
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 32; i++) begin
            // r1 plus r2 overflows by exactly one, so carry-out is always exercised
            regs_r[i] <= (i == 1) ? 32'hFFFFFFFF :
                         (i == 2) ? 32'h00000001 : 32'(i) * 32'h11111111;
         end
      end else if (wb.valid && wb.dest != 5'h0) begin
         regs_r[wb.dest] <= wb.data;
      end
   end

   // Read in the issue cycle, as a real file port would
   assign src_reg_a = regs_r[instr.word[20:16]];
   assign src_reg_b = regs_r[instr.word[15:11]];
endmodule
